// File: buwsg_top.sv
// Upstream window, preemption and system-error gating register bank
//
// Operation
// RULE1 - Preempt field 31:28; top bit disables
// RULE2 - Codes map to 0,1,2,4..64 clocks
// RULE3 - Window low nibbles read one: 64-bit
// RULE4 - Writable base bits 15:4, reset zero
// RULE5 - Writable limit bits 31:20, printed reset
// RULE6 - Upper 32 base bits register
// RULE7 - Upper 32 limit bits register
// RULE8 - Mask zero plus enable asserts error
// RULE9 - Bit 1 gates posted-write parity error
// RULE10 - Bit 2 gates posted-write non-delivery
// RULE11 - Bit 3 gates posted-write target abort
// RULE12 - Bit 4 gates posted-write master abort
// RULE13 - Bit 5 gates delayed-write non-delivery
// RULE14 - Bit 6 gates delayed-read no data
// RULE15 - Mask bits 0, 7 reserved zero
// RULE16 - Window enable confines upstream claims
// RULE17 - 1 MB granularity for window compare
// RULE18 - Elapsed delay plus request drops grant
`timescale 1ns/100ps
`default_nettype none
module buwsg_top
    import buwsg_pkg::*;
(
    input  wire logic        clk,                  // PCI clock, 125 MHz
    input  wire logic        rst_n,                // Chip reset, active low
    input  wire buwsg_cfg_t  cfg,                  // Configuration access
    output logic [31:0]      cfg_rdata,            // Read data
    input  wire logic        cmd_system_error_enable, // Command enable
    input  wire logic        win_enable,           // Upstream range enable
    input  wire logic        down_hit,             // In downstream window
    input  wire logic [63:0] up_addr,              // Secondary address
    output logic             up_claim,             // Forward upstream
    input  wire logic [7:0]  evt,                  // Error event pulses
    output logic             primary_system_error_out, // Error request
    input  wire buwsg_arb_t  arb,                  // Secondary bus state
    output logic             arb_preempt           // Deassert grant
);

    // Register map, one dword per offset:
    //   4c preemption nibble in bits 31:28
    //   50 base bits 15:4, limit bits 31:20
    //   54 and 58 upper halves of base and limit
    //   64 event mask, bits 6:1 writable
    // Writes land at the edge that takes the strobe; reads return
    // one cycle later from a register, so read data never hangs
    // combinationally on the strobe that asked for it.
    // Preemption: timer counts from frame start and drops the
    // grant once the delay is over and another master asks.
    // Error path: an unmasked event with the enable set raises
    // the request one cycle later.

    // Register state
    logic [3:0]  preempt_q;     // Preemption control
    logic [11:0] base_q;        // Base address bits 31:20
    logic [11:0] limit_q;       // Limit address bits 31:20
    logic [31:0] base_hi_q;     // Base address bits 63:32
    logic [31:0] limit_hi_q;    // Limit address bits 63:32
    logic [7:0]  mask_q;        // Event disable mask
    logic [31:0] rdata_q;       // Registered read data
    logic        serr_q;        // Registered error request

    // Write strobe per register
    // At most one is high, since offsets differ
    logic        wr_pre;        // Preemption register
    logic        wr_win;        // Base/limit low register
    logic        wr_bhi;        // Base upper register
    logic        wr_lhi;        // Limit upper register
    logic        wr_msk;        // Event mask register

    // Address match helper, used for every register
    // Offset bits 1:0 never decode; byte enables alone pick lanes
    // Shared by write strobes and read mux alike
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a[7:2] == o[7:2];
    endfunction

    // Byte-merge helper for byte-enabled writes
    // Lanes with enable low keep the old image, so a
    // partial write leaves other fields of the dword alone
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Unmapped offsets match no strobe, so such
    // writes are simply ignored
    assign wr_pre = cfg.wr && hit(cfg.addr, OFS_PREEMPT);
    assign wr_win = cfg.wr && hit(cfg.addr, OFS_WIN_LOW);
    assign wr_bhi = cfg.wr && hit(cfg.addr, OFS_BASE_HIGH);
    assign wr_lhi = cfg.wr && hit(cfg.addr, OFS_LIMIT_HIGH);
    assign wr_msk = cfg.wr && hit(cfg.addr, OFS_EVT_MASK);

    // Current register images as read back
    // Shared by the read mux and the write merge
    logic [31:0] img_pre;       // Preemption dword
    logic [31:0] img_win;       // Base/limit low dword
    logic [31:0] img_msk;       // Mask dword

    // Only the top nibble is implemented in the preemption dword
    // Bits 27:0 have no storage and read zero
    assign img_pre = {preempt_q, 28'h0000000};
    // Capability nibbles are constant ones
    assign img_win = {limit_q, ADDR64_CAP, base_q, ADDR64_CAP};  // [RULE3]
    // Reserved mask bits never stored, read zero
    assign img_msk = {24'h000000, mask_q & MASK_WR_BITS};        // [RULE15]

    // Merged write values
    // Built from the read image, so read-only bits
    // merge as their fixed values and then drop out
    logic [31:0] nxt_pre;       // Preemption after write
    logic [31:0] nxt_win;       // Window low after write
    logic [31:0] nxt_bhi;       // Base upper after write
    logic [31:0] nxt_lhi;       // Limit upper after write
    logic [31:0] nxt_msk;       // Mask after write

    assign nxt_pre = merge(img_pre, cfg.wdata, cfg.be);
    assign nxt_win = merge(img_win, cfg.wdata, cfg.be);
    assign nxt_bhi = merge(base_hi_q, cfg.wdata, cfg.be);
    assign nxt_lhi = merge(limit_hi_q, cfg.wdata, cfg.be);
    assign nxt_msk = merge(img_msk, cfg.wdata, cfg.be);

    // Preemption control field
    // Only byte lane 3 reaches the stored nibble
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Delay of zero after reset
            preempt_q <= PREEMPT_RST;                           // [RULE2]
        end
        else if (wr_pre)
        begin
            // Top nibble of the merged dword
            preempt_q <= nxt_pre[PREEMPT_LSB +: 4];             // [RULE1]
        end
    end

    // Lower window base and limit fields
    // Capability nibbles fall away from the merged value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Both fields clear at reset
            base_q  <= BASE_RST;                                // [RULE4]
            limit_q <= LIMIT_RST;                               // [RULE5]
        end
        else if (wr_win)
        begin
            // Fields taken from their byte lanes
            base_q  <= nxt_win[BASE_LSB +: 12];                 // [RULE4]
            limit_q <= nxt_win[LIMIT_LSB +: 12];                // [RULE5]
        end
    end

    // Upper base address dword
    // All 32 bits writable, byte lanes honoured
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Window starts below 4 GB after reset
            base_hi_q <= HIGH_RST;                              // [RULE6]
        end
        else if (wr_bhi)
        begin
            // Merged dword as written
            base_hi_q <= nxt_bhi;                               // [RULE6]
        end
    end

    // Upper limit address dword
    // All 32 bits writable, byte lanes honoured
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Limit below 4 GB after reset
            limit_hi_q <= HIGH_RST;                             // [RULE7]
        end
        else if (wr_lhi)
        begin
            // Merged dword as written
            limit_hi_q <= nxt_lhi;                              // [RULE7]
        end
    end

    // Event mask; reserved bits forced to zero
    // A stored one disables that event
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Every event reports after reset
            mask_q <= MASK_RST;                                 // [RULE8]
        end
        else if (wr_msk)
        begin
            // Reserved bits dropped on the way in
            mask_q <= nxt_msk[7:0] & MASK_WR_BITS;              // [RULE15]
        end
    end

    // Read mux, registered; unmapped offsets read zero
    // Value stands until the next read strobe
    // Read and write in one cycle return the old value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (cfg.rd)
        begin
            // Preemption nibble over zeros
            if (hit(cfg.addr, OFS_PREEMPT))
            begin
                rdata_q <= img_pre;
            end
            // Low window dword with fixed capability
            else if (hit(cfg.addr, OFS_WIN_LOW))
            begin
                rdata_q <= img_win;                             // [RULE3]
            end
            // Upper base half
            else if (hit(cfg.addr, OFS_BASE_HIGH))
            begin
                rdata_q <= base_hi_q;
            end
            // Upper limit half
            else if (hit(cfg.addr, OFS_LIMIT_HIGH))
            begin
                rdata_q <= limit_hi_q;
            end
            // Mask with reserved bits clear
            else if (hit(cfg.addr, OFS_EVT_MASK))
            begin
                rdata_q <= img_msk;
            end
            else
            begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    // Read data straight from the flip-flop
    assign cfg_rdata = rdata_q;

    // Full 64-bit window bounds with 1 MB granularity
    // Both ends inclusive: base pads its low 20 bits with
    // zeros, limit with ones. A base above the limit
    // leaves the window empty and claims nothing.
    logic [63:0] win_lo;        // Lowest claimed address
    logic [63:0] win_hi;        // Highest claimed address
    logic        in_win;        // Address inside window

    assign win_lo = {base_hi_q, base_q, {GRAN_BITS{1'b0}}};     // [RULE17]
    assign win_hi = {limit_hi_q, limit_q, {GRAN_BITS{1'b1}}};   // [RULE17]
    // Unsigned compare across all 64 bits
    assign in_win = (up_addr >= win_lo) && (up_addr <= win_hi);

    // Claim selection by window enable
    // Clear: all outside the downstream window goes up
    always_comb
    begin
        if (win_enable)
        begin
            // Only the programmed range
            up_claim = in_win;                                  // [RULE16]
        end
        else
        begin
            // Complement of the downstream window
            up_claim = ~down_hit;                               // [RULE16]
        end
    end

    // Per-event gating of the system error request
    // Only positions 6:1 carry events
    logic [7:0] evt_pass;       // Events not disabled

    // One gate per event position
    genvar g;
    generate
        for (g = EVT_PW_PARITY; g <= EVT_DR_NODATA; g++)
        begin : g_gate
            // Mask bit clear lets the event through [RULE9] [RULE10]
            // Abort events share this gate [RULE11] [RULE12]
            assign evt_pass[g] = evt[g] & ~mask_q[g]; // [RULE13] [RULE14]
        end
    endgenerate
    // Reserved positions never pass
    assign evt_pass[0] = 1'b0;                                  // [RULE15]
    assign evt_pass[7] = 1'b0;                                  // [RULE15]

    // Registered error request, needs command enable too
    // High one cycle per event cycle; the pin driver inverts
    // it, and enable low holds it off whatever the mask says
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // No request during reset
            serr_q <= 1'b0;
        end
        else
        begin
            serr_q <= cmd_system_error_enable && (|evt_pass);   // [RULE8]
        end
    end

    // Request straight from the flip-flop
    assign primary_system_error_out = serr_q;

    // Preemption timer
    // Gets the stored nibble; decodes and gates it itself
    buwsg_preempt u_preempt
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .code    (preempt_q),
        .arb     (arb),
        .preempt (arb_preempt)
    );

endmodule
`default_nettype wire

// File: buwsg_pkg.sv
// Package: offsets, fields, reset values and types for the upstream window block
package buwsg_pkg;

    // Configuration dword offsets
    localparam logic [7:0] OFS_PREEMPT    = 8'h4c;
    localparam logic [7:0] OFS_WIN_LOW    = 8'h50;
    localparam logic [7:0] OFS_BASE_HIGH  = 8'h54;
    localparam logic [7:0] OFS_LIMIT_HIGH = 8'h58;
    localparam logic [7:0] OFS_EVT_MASK   = 8'h64;

    // Field positions
    localparam int PREEMPT_LSB   = 28;
    localparam int BASE_LSB      = 4;
    localparam int LIMIT_LSB     = 20;
    localparam int LIMIT_CAP_LSB = 16;
    localparam int GRAN_BITS     = 20;

    // Reset values and read-only contents
    localparam logic [3:0]  PREEMPT_RST  = 4'h0;
    localparam logic [11:0] BASE_RST     = 12'h000;
    localparam logic [11:0] LIMIT_RST    = 12'h000;
    localparam logic [3:0]  ADDR64_CAP   = 4'h1;
    localparam logic [31:0] HIGH_RST     = 32'h0000_0000;
    localparam logic [7:0]  MASK_RST     = 8'h00;
    localparam logic [7:0]  MASK_WR_BITS = 8'h7e;

    // Event indices in the mask register
    localparam int EVT_PW_PARITY   = 1;
    localparam int EVT_PW_NODELIV  = 2;
    localparam int EVT_PW_TABORT   = 3;
    localparam int EVT_PW_MABORT   = 4;
    localparam int EVT_DW_NODELIV  = 5;
    localparam int EVT_DR_NODATA   = 6;

    // Preemption delay decode limits
    localparam logic [6:0] PREEMPT_MAX_CYC = 7'h40;

    // Configuration access carrier
    typedef struct packed {
        logic        rd;      // Read strobe
        logic        wr;      // Write strobe
        logic [7:0]  addr;    // Dword-aligned offset
        logic [3:0]  be;      // Byte enables
        logic [31:0] wdata;   // Write data
    } buwsg_cfg_t;

    // Arbiter-side carrier from the secondary bus
    typedef struct packed {
        logic frame_start;    // Pulse when FRAME is first asserted
        logic frame_active;   // FRAME or transaction in progress
        logic other_req;      // Another master requests the bus
    } buwsg_arb_t;

endpackage

// File: buwsg_preempt.sv
// Secondary arbiter preemption timer
`timescale 1ns/100ps
`default_nettype none
module buwsg_preempt
    import buwsg_pkg::*;
(
    input  wire logic       clk,          // PCI clock
    input  wire logic       rst_n,        // Synchronous reset, active low
    input  wire logic [3:0] code,         // Preemption control field
    input  wire buwsg_arb_t arb,          // Secondary bus activity
    output logic            preempt       // Drop current grant
);

    // Decode a preemption code into a cycle count
    function automatic logic [6:0] decode_delay(input logic [3:0] c);
        logic [6:0] r;
        r = 7'h00;
        unique case (c[2:0])
            3'h0: r = 7'h00;
            3'h1: r = 7'h01;
            3'h2: r = 7'h02;
            3'h3: r = 7'h04;
            3'h4: r = 7'h08;
            3'h5: r = 7'h10;
            3'h6: r = 7'h20;
            3'h7: r = PREEMPT_MAX_CYC;
        endcase
        return r;
    endfunction

    logic [6:0] cnt_q;     // Cycles since FRAME asserted
    logic       run_q;     // Timer running within a transaction
    logic [6:0] delay;     // Decoded delay
    logic       enabled;   // Preemption not switched off
    logic [6:0] elapsed;   // Cycles since FRAME asserted, zero in that cycle

    assign delay   = decode_delay(code);               // [RULE2]
    assign enabled = ~code[3];                         // [RULE1]
    assign elapsed = arb.frame_start ? 7'h00 : cnt_q;

    // Count cycles from FRAME assertion, saturating at PREEMPT_MAX_CYC
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= 7'h00;
            run_q <= 1'b0;
        end
        else if (arb.frame_start)
        begin
            cnt_q <= 7'h01;
            run_q <= 1'b1;
        end
        else if (!arb.frame_active)
        begin
            run_q <= 1'b0;
        end
        else if (run_q && cnt_q != PREEMPT_MAX_CYC)
        begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

    // Remove grant once the delay elapsed and someone else waits
    assign preempt = enabled && arb.other_req
                     && (run_q || arb.frame_start)
                     && (elapsed >= delay);            // [RULE18]

endmodule
`default_nettype wire

// File: buwsg_asserts.sv
// Checker for the upstream window block, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module buwsg_asserts
    import buwsg_pkg::*;
(
    input  wire logic        clk,                      // PCI clock
    input  wire logic        rst_n,                    // Sync reset, low
    input  wire buwsg_cfg_t  cfg,                      // Config access
    input  wire logic [31:0] cfg_rdata,                // Read data
    input  wire logic        cmd_system_error_enable,  // Error enable
    input  wire logic        win_enable,               // Range enable
    input  wire logic        down_hit,                 // Downstream hit
    input  wire logic        up_claim,                 // Upstream claim
    input  wire logic [7:0]  evt,                      // Event pulses
    input  wire logic        primary_system_error_out, // Error request
    input  wire buwsg_arb_t  arb,                      // Secondary bus
    input  wire logic        arb_preempt               // Drop grant
);
    logic [3:0] code_q; // Shadow of preemption field
    logic [7:0] mask_q; // Shadow of event mask
    logic [6:0] age_q;  // Cycles since frame start
    logic [6:0] age;    // Age in this cycle
    logic [6:0] dly;    // Decoded delay
    logic       fire;   // Enabled, unmasked event
    assign age  = arb.frame_start ? 7'h00 : age_q;
    assign dly  = (code_q < 4'h3) ? {5'h00, code_q[1:0]}
                                  : 7'h01 << (code_q[2:0] - 3'h1);
    assign fire = cmd_system_error_enable && |(evt & ~mask_q & MASK_WR_BITS);
    // Shadows follow configuration writes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            code_q <= PREEMPT_RST;
            mask_q <= MASK_RST;
        end
        else if (cfg.wr)
        begin
            if (cfg.addr[7:2] == OFS_PREEMPT[7:2] && cfg.be[3])
                code_q <= cfg.wdata[31:28];
            if (cfg.addr[7:2] == OFS_EVT_MASK[7:2] && cfg.be[0])
                mask_q <= cfg.wdata[7:0];
        end
    end
    // Saturating age, restarted by each frame start
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            age_q <= 7'h7f;
        else
            age_q <= (age == 7'h7f) ? age : age + 7'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Read request to one dword offset
    sequence s_rd(logic [5:0] a);
        cfg.rd && cfg.addr[7:2] == a;
    endsequence
    AST_PREEMPT_RO:
        assert property (s_rd(OFS_PREEMPT[7:2]) |=> cfg_rdata[27:0] == 28'h0)
        else $error("preempt low bits not zero");
    AST_ADDR64_CAP:
        assert property (s_rd(OFS_WIN_LOW[7:2]) |=> cfg_rdata[3:0] == 4'h1
                         && cfg_rdata[19:16] == 4'h1)
        else $error("window capability nibbles wrong");
    AST_MASK_RSV:
        assert property (s_rd(OFS_EVT_MASK[7:2])
                         |=> !cfg_rdata[0] && !cfg_rdata[7])
        else $error("reserved mask bits not zero");
    AST_SERR_FIRE:
        assert property (fire |=> primary_system_error_out)
        else $error("error request missing");
    AST_SERR_QUIET:
        assert property (!fire |=> !primary_system_error_out)
        else $error("error request without cause");
    AST_PREEMPT_OFF:
        assert property (code_q[3] |-> !arb_preempt)
        else $error("preempt while disabled");
    AST_PREEMPT_EARLY:
        assert property (arb_preempt |-> age >= dly && arb.other_req)
        else $error("preempt too early");
    AST_PREEMPT_DUE:
        assert property (!code_q[3] && age == dly && arb.frame_active
                         && arb.other_req |-> arb_preempt)
        else $error("preempt missing when due");
    AST_CLAIM_ALL:
        assert property (!win_enable |-> up_claim == !down_hit)
        else $error("claim outside downstream wrong");
endmodule
bind buwsg_top buwsg_asserts u_asserts (.clk, .rst_n, .cfg, .cfg_rdata,
    .cmd_system_error_enable, .win_enable, .down_hit, .up_claim, .evt,
    .primary_system_error_out, .arb, .arb_preempt);
`default_nettype wire

// File: buwsg_host.sv
// Host model issuing configuration cycles to the block
`timescale 1ns/100ps
`default_nettype none
module buwsg_host
    import buwsg_pkg::*;
(
    input  wire logic        clk,       // PCI clock
    input  wire logic [31:0] cfg_rdata, // Read data from the block
    output var  buwsg_cfg_t  cfg        // Configuration access
);
    // Idle bus at start
    initial cfg = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, be: 4'h0, wdata: 32'h0};
    // One write; data inverted afterwards so stale values never linger
    task automatic wr(input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        @(negedge clk);
        cfg = '{rd: 1'b0, wr: 1'b1, addr: a, be: b, wdata: d};
        @(negedge clk);
        cfg.wr = 1'b0;
        cfg.wdata = ~d;
    endtask
    // One read; data is registered at the edge that takes the request
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        cfg.rd = 1'b1;
        cfg.addr = a;
        @(negedge clk);
        cfg.rd = 1'b0;
        d = cfg_rdata;
    endtask
endmodule
`default_nettype wire

// File: test_bridge_upstream_window_serr_gating.sv
// Testbench for the upstream window, preemption and error gating block
`timescale 1ns/100ps
`default_nettype none
module test_bridge_upstream_window_serr_gating
    import buwsg_pkg::*;
;
    logic        clk;                // PCI clock
    logic        rst_n;              // Reset, active low
    buwsg_cfg_t  cfg;                // Host access
    logic [31:0] cfg_rdata;          // Read data
    logic        serr_en;            // Command error enable
    logic        win_enable;         // Range enable
    logic        down_hit;           // Downstream hit
    logic [63:0] up_addr;            // Compared address
    logic        up_claim;           // Upstream claim
    logic [7:0]  evt;                // Event pulses
    logic        serr;               // Error request
    buwsg_arb_t  arb;                // Secondary bus state
    logic        preempt;            // Grant drop
    logic [31:0] rdv;                // Last read value
    logic        x;                  // Expected error request
    int          miscompares = 0;    // Mismatches
    int          check_count = 0;    // Comparisons
    int          cycles = 0;         // Timeout counter
    int          k;                  // Loop index
    int          n;                  // Cycles to preemption
    logic [7:0]  ofs [6] = '{OFS_PREEMPT, OFS_WIN_LOW, OFS_BASE_HIGH,
                             OFS_LIMIT_HIGH, OFS_EVT_MASK, 8'h60};
    logic [31:0] rv [6] = '{32'h0, 32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] wv [6] = '{32'hf000_0000, 32'hfff1_fff1, 32'hffff_ffff,
                            32'hffff_ffff, 32'h0000_007e, 32'h0};
    int          dly [9] = '{0, 1, 2, 4, 8, 16, 32, 64, 80};
    buwsg_top dut (.clk, .rst_n, .cfg, .cfg_rdata,
        .cmd_system_error_enable(serr_en), .win_enable, .down_hit, .up_addr,
        .up_claim, .evt, .primary_system_error_out(serr), .arb,
        .arb_preempt(preempt));
    buwsg_host u_host (.clk, .cfg_rdata, .cfg);
    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            tally_and_finish;
        end
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        u_host.rd(a, rdv);
        chk(rdv, e);
    endtask
    // Event pulse, request checked one cycle later
    task automatic pulse(input logic [7:0] e, input logic ex);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = 8'h0;
        chk(32'(serr), 32'(ex));
    endtask
    task automatic claim(input logic [63:0] a, input logic e);
        up_addr = a;
        #1;
        chk(32'(up_claim), 32'(e));
        @(negedge clk);
    endtask
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        serr_en = 1'b1;
        win_enable = 1'b0;
        down_hit = 1'b0;
        up_addr = 64'h0;
        evt = 8'h00;
        arb = '0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        // Reset values, then all ones written and read back
        foreach (ofs[i])
            rdchk(ofs[i], rv[i]);
        foreach (ofs[i])
        begin
            u_host.wr(ofs[i], 4'hf, 32'hffff_ffff);
            rdchk(ofs[i], wv[i]);
        end
        u_host.wr(OFS_WIN_LOW, 4'h3, 32'h0);
        rdchk(OFS_WIN_LOW, 32'hfff1_0001);
        // Each event alone, with others masked, then itself masked
        for (k = 0; k < 8; k++)
        begin
            x = (k > 0 && k < 7);
            u_host.wr(OFS_EVT_MASK, 4'h1, 32'h0);
            pulse(8'h01 << k, x);
            u_host.wr(OFS_EVT_MASK, 4'h1, ~(32'h1 << k));
            pulse(8'hff, x);
            u_host.wr(OFS_EVT_MASK, 4'h1, 32'h1 << k);
            pulse(8'h01 << k, 1'b0);
        end
        serr_en = 1'b0;
        u_host.wr(OFS_EVT_MASK, 4'h1, 32'h0);
        pulse(8'h7e, 1'b0);
        // Preemption delay for codes 0 to 8, 80 meaning never
        for (k = 0; k < 9; k++)
        begin
            u_host.wr(OFS_PREEMPT, 4'h8, 32'(k) << 28);
            @(negedge clk);
            arb = '{frame_start: 1'b1, frame_active: 1'b1, other_req: 1'b1};
            #1;
            n = 0;
            while (preempt !== 1'b1 && n < 80)
            begin
                @(negedge clk);
                arb.frame_start = 1'b0;
                #1;
                n++;
            end
            chk(32'(n), 32'(dly[k]));
            @(negedge clk);
            arb = '0;
        end
        // Window compare at 1 MB granularity
        u_host.wr(OFS_WIN_LOW, 4'hf, 32'h0020_0010);
        u_host.wr(OFS_BASE_HIGH, 4'hf, 32'h0);
        u_host.wr(OFS_LIMIT_HIGH, 4'hf, 32'h0);
        win_enable = 1'b1;
        claim(64'h0_000f_ffff, 1'b0);
        claim(64'h0_0010_0000, 1'b1);
        claim(64'h0_002f_ffff, 1'b1);
        claim(64'h0_0030_0000, 1'b0);
        u_host.wr(OFS_BASE_HIGH, 4'hf, 32'h1);
        u_host.wr(OFS_LIMIT_HIGH, 4'hf, 32'h1);
        claim(64'h1_0010_0000, 1'b1);
        claim(64'h0_0010_0000, 1'b0);
        win_enable = 1'b0;
        down_hit = 1'b1;
        claim(64'h0, 1'b0);
        down_hit = 1'b0;
        claim(64'h0, 1'b1);
        // Second reset in mid-run
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rdchk(OFS_PREEMPT, 32'h0);
        rdchk(OFS_LIMIT_HIGH, 32'h0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
